/* inc/cssw_pkg.sv */
// package for the crosspoint source-select block: register map, field layout, reset values
// assumes a single 100 MHz clock domain and an apb master with 32-bit data
`default_nettype none
package cssw_pkg;
   localparam int PORTS = 8;
   localparam int SEL_W = 3;
   localparam int ADDR_W = 8;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PRI_BASE_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] SEC_BASE_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h44;
   // ----------------------------------------------------------------
   // fields
   // ----------------------------------------------------------------
   localparam int SEL_LSB = 0;
   localparam int CTRL_SW_BIT = 0;
   localparam int CTRL_PINEN_BIT = 1;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam logic CTRL_SW_RST = 1'h0;
   localparam logic CTRL_PINEN_RST = 1'h0;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } cssw_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cssw_apb_rsp_t;
endpackage
`default_nettype wire

/* design/cssw_top.sv */
// source-select control of an 8x8 crosspoint: primary/secondary profiles and switch event
// assumes apb master on clk, trigger pin already synchronous to clk
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module cssw_top (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic register_reset_pin_n,
   // switch trigger
   input wire logic switch_trigger_pin,
   // apb slave
   input wire cssw_pkg::cssw_apb_req_t apb_req,
   output var cssw_pkg::cssw_apb_rsp_t apb_rsp,
   // crosspoint selects, output o takes bits [3o+2:3o]
   output logic [cssw_pkg::PORTS*cssw_pkg::SEL_W-1:0] out_sel,
   output logic secondary_active
);
   localparam int N = cssw_pkg::PORTS;
   localparam int W = cssw_pkg::SEL_W;
   // word index within one eight-word profile bank
   localparam int ADDR_IDX_W = $clog2(N);

   typedef struct packed {
      logic [N-1:0][W-1:0] pri;
      logic [N-1:0][W-1:0] sec;
      logic sw_bit;
      logic pin_en;
      logic [N-1:0][W-1:0] sel_out;
      logic active;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cssw_state_t;

   cssw_state_t state_reg, state_next;
   logic rst_sync1_reg, rst_sync2_reg;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   // asserted at once, released on a clock edge two flops deep
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end

   function automatic logic [N-1:0][W-1:0] ident_map();
      logic [N-1:0][W-1:0] m;
      m = '0;
      for (int i = 0; i < N; i++) begin
         m[i] = W'(i);
      end
      return m;
   endfunction

   // straight-through map used at reset and by the register reset pin
   localparam logic [N-1:0][W-1:0] IDENT_MAP = ident_map();

   // ----------------------------------------------------------------
   // profile choice and output multiplexers
   // ----------------------------------------------------------------
   logic sel_sec;
   logic [N-1:0][W-1:0] mux_sel;

   // the pin path bypasses the register bus, so a pin edge reaches the
   // outputs one cycle later instead of after a whole bus write
   always_comb begin
      if (state_reg.pin_en) begin
         sel_sec = switch_trigger_pin;
      end else begin
         sel_sec = state_reg.sw_bit;
      end
   end

   // one global choice fans out to every output multiplexer
   for (genvar o = 0; o < N; o++) begin : g_out_mux
      cssw_src_mux #(
         .SEL_W(W)
      ) u_mux (
         .pri_sel(state_reg.pri[o]),
         .sec_sel(state_reg.sec[o]),
         .use_sec(sel_sec),
         .sel(mux_sel[o])
      );
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic pri_hit;
   logic sec_hit;
   logic ctrl_hit;
   logic stat_hit;

   // an unaligned address hits nothing and ends in an error response
   always_comb begin
      logic aligned;
      aligned = apb_req.paddr[1:0] == 2'h0;
      pri_hit = 1'b0;
      sec_hit = 1'b0;
      ctrl_hit = 1'b0;
      stat_hit = 1'b0;
      if (aligned && apb_req.paddr >= cssw_pkg::PRI_BASE_OFS
          && apb_req.paddr < cssw_pkg::SEC_BASE_OFS) begin
         pri_hit = 1'b1;
      end else if (aligned && apb_req.paddr < cssw_pkg::CTRL_OFS) begin
         sec_hit = 1'b1;
      end else if (apb_req.paddr == cssw_pkg::CTRL_OFS) begin
         ctrl_hit = 1'b1;
      end else if (apb_req.paddr == cssw_pkg::STAT_OFS) begin
         stat_hit = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic setup;
      logic wr;
      logic rd;
      logic [ADDR_IDX_W-1:0] idx;
      setup = apb_req.psel && !apb_req.penable;
      wr = setup && apb_req.pwrite;
      rd = setup && !apb_req.pwrite;
      idx = apb_req.paddr[2 +: ADDR_IDX_W];
      state_next = state_reg;
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
      // decode in setup and answer in the access phase, with no wait states
      if (setup) begin
         state_next.pready = 1'b1;
         state_next.prdata = 32'h0000_0000;
         if (pri_hit) begin
            if (wr) state_next.pri[idx] = apb_req.pwdata[cssw_pkg::SEL_LSB +: W];
            if (rd) state_next.prdata[cssw_pkg::SEL_LSB +: W] = state_reg.pri[idx];
         end else if (sec_hit) begin
            if (wr) state_next.sec[idx] = apb_req.pwdata[cssw_pkg::SEL_LSB +: W];
            if (rd) state_next.prdata[cssw_pkg::SEL_LSB +: W] = state_reg.sec[idx];
         end else if (ctrl_hit) begin
            if (wr) begin
               state_next.sw_bit = apb_req.pwdata[cssw_pkg::CTRL_SW_BIT];
               state_next.pin_en = apb_req.pwdata[cssw_pkg::CTRL_PINEN_BIT];
            end
            if (rd) begin
               state_next.prdata[cssw_pkg::CTRL_SW_BIT] = state_reg.sw_bit;
               state_next.prdata[cssw_pkg::CTRL_PINEN_BIT] = state_reg.pin_en;
            end
         end else if (stat_hit) begin
            if (rd) state_next.prdata[cssw_pkg::STAT_ACTIVE_BIT] = state_reg.active;
            if (wr) state_next.pslverr = 1'b1;
         end else begin
            state_next.pslverr = 1'b1;
         end
      end
      // outputs and status follow the profile choice one edge later
      state_next.active = sel_sec;
      state_next.sel_out = mux_sel;
      // register reset pin clears the register space back to straight-through
      if (!register_reset_pin_n) begin
         state_next.pri = IDENT_MAP;
         state_next.sec = IDENT_MAP;
         state_next.sw_bit = cssw_pkg::CTRL_SW_RST;
         state_next.pin_en = cssw_pkg::CTRL_PINEN_RST;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync2_reg) begin
      if (!rst_sync2_reg) begin
         state_reg.pri <= IDENT_MAP;
         state_reg.sec <= IDENT_MAP;
         state_reg.sw_bit <= cssw_pkg::CTRL_SW_RST;
         state_reg.pin_en <= cssw_pkg::CTRL_PINEN_RST;
         state_reg.sel_out <= IDENT_MAP;
         state_reg.active <= 1'b0;
         state_reg.prdata <= 32'h0000_0000;
         state_reg.pready <= 1'b0;
         state_reg.pslverr <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output is a register bit with no logic after it
   assign out_sel = state_reg.sel_out;
   assign secondary_active = state_reg.active;
   assign apb_rsp.prdata = state_reg.prdata;
   assign apb_rsp.pready = state_reg.pready;
   assign apb_rsp.pslverr = state_reg.pslverr;
endmodule

// ----------------------------------------------------------------
// per-output source multiplexer
// ----------------------------------------------------------------
// picks one profile's input index; instantiated once per output port
module cssw_src_mux #(
   parameter int SEL_W = 3
) (
   // profile selects
   input wire logic [SEL_W-1:0] pri_sel,
   input wire logic [SEL_W-1:0] sec_sel,
   // global profile choice
   input wire logic use_sec,
   // chosen input index
   output logic [SEL_W-1:0] sel
);
   assign sel = use_sec ? sec_sel : pri_sel;
endmodule

`default_nettype wire

/* dv/cssw_trig_model.sv */
// external trigger logic that drives the switch trigger pin
// assumes the bench asks for a level on want; the pin moves after the next rising edge
`timescale 1ns/10ps
`default_nettype none
module cssw_trig_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // request and pin
   input wire logic want,
   output var logic pin
);
   // registered so the block never sees a level change inside its own edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin <= 1'h0;
      end else begin
         pin <= want;
      end
   end
endmodule
`default_nettype wire

/* dv/cssw_top_props.sv */
// checker for cssw_top, bound to its ports
// assumes zero-wait apb and a trigger pin synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module cssw_top_props (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic register_reset_pin_n,
   input wire logic switch_trigger_pin,
   // bus and selects
   input wire cssw_pkg::cssw_apb_req_t apb_req,
   input wire cssw_pkg::cssw_apb_rsp_t apb_rsp,
   input wire logic [cssw_pkg::PORTS*cssw_pkg::SEL_W-1:0] out_sel,
   input wire logic secondary_active
);
   logic setup, ctrl_wr, pe_q, sw_q;
   assign setup = apb_req.psel && !apb_req.penable;
   assign ctrl_wr = setup && apb_req.pwrite && apb_req.paddr == cssw_pkg::CTRL_OFS;
   // shadow of the control bits, updated on the same edges as the block
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {pe_q, sw_q} <= 2'h0;
      end else if (!register_reset_pin_n) begin
         {pe_q, sw_q} <= 2'h0;
      end else if (ctrl_wr) begin
         {pe_q, sw_q} <= apb_req.pwdata[1:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_sw_on;
      ctrl_wr && apb_req.pwdata[1:0] == 2'h1 && register_reset_pin_n;
   endsequence
   sequence s_regrst;
      !register_reset_pin_n ##1 !register_reset_pin_n;
   endsequence
   a_ready_next: assert property (setup |=> apb_rsp.pready) else $error("pready late");
   a_ready_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
      else $error("stray pready");
   a_err_in_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("stray err");
   a_active_choice: assert property (secondary_active ==
      ($past(pe_q) ? $past(switch_trigger_pin) : $past(sw_q))) else $error("wrong profile");
   a_sw_switch: assert property (s_sw_on |-> ##2 secondary_active) else $error("no switch");
   a_pin_rise: assert property (pe_q && $rose(switch_trigger_pin) |=> secondary_active)
      else $error("pin rise ignored");
   a_pin_fall: assert property (pe_q && $fell(switch_trigger_pin) |=> !secondary_active)
      else $error("pin fall ignored");
   a_regrst_ident: assert property (s_regrst |=> out_sel == 24'hFAC688 && !secondary_active)
      else $error("no identity map");
endmodule
bind cssw_top cssw_top_props u_props (.clk(clk), .rstn(rstn),
   .register_reset_pin_n(register_reset_pin_n), .switch_trigger_pin(switch_trigger_pin),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .out_sel(out_sel), .secondary_active(secondary_active));
`default_nettype wire

/* dv/cssw_top_bench.sv */
// bench for cssw_top: apb master task and one task per scenario
// assumes cssw_trig_model drives the trigger pin
`timescale 1ns/10ps
`default_nettype none
module cssw_top_bench;
   logic clk = 1'h0, rstn = 1'h0, rr_n = 1'h1, want = 1'h0, pin, sec, e;
   logic [31:0] r;
   logic [23:0] sel;
   cssw_pkg::cssw_apb_req_t req = '0;
   cssw_pkg::cssw_apb_rsp_t rsp;
   int fails = 0, checks_done = 0;
   cssw_top uut (.clk(clk), .rstn(rstn), .register_reset_pin_n(rr_n), .switch_trigger_pin(pin),
      .apb_req(req), .apb_rsp(rsp), .out_sel(sel), .secondary_active(sec));
   cssw_trig_model trig (.clk(clk), .rstn(rstn), .want(want), .pin(pin));
   initial forever #5 clk = ~clk;
   function automatic logic [23:0] pat(input logic s);
      logic [23:0] v;
      for (int o = 0; o < 8; o++) v[3*o +: 3] = s ? 3'(7 - o) : 3'(o + 1);
      return v;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) req <= '{a, 1'h1, 1'h0, w, d};
      @(posedge clk) req.penable <= 1'h1;
      // no cycle count is assumed; a slave that never answers is left to the watchdog
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'h1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'h0;
      req.penable <= 1'h0;
   endtask
   task automatic t_reset();
      chk("sel", {8'h0, sel}, {8'h0, 24'hFAC688});
      apb(1'h0, 8'h0C, 32'h0);
      chk("pri3", r, 32'h3);
   endtask
   task automatic t_sw();
      for (int o = 0; o < 8; o++) begin
         apb(1'h1, 8'(4 * o), 32'((o + 1) % 8));
         apb(1'h1, 8'(32 + 4 * o), 32'(7 - o));
      end
      tick(2);
      chk("pri", {8'h0, sel}, {8'h0, pat(1'h0)});
      apb(1'h1, cssw_pkg::CTRL_OFS, 32'h1);
      tick(1);
      chk("sec", {8'h0, sel}, {8'h0, pat(1'h1)});
      chk("act", {31'h0, sec}, 32'h1);
      apb(1'h0, cssw_pkg::STAT_OFS, 32'h0);
      chk("stat", r, 32'h1);
      apb(1'h1, cssw_pkg::CTRL_OFS, 32'h0);
      tick(1);
      chk("back", {8'h0, sel}, {8'h0, pat(1'h0)});
   endtask
   task automatic t_pin();
      apb(1'h1, cssw_pkg::CTRL_OFS, 32'h3);
      tick(1);
      chk("ign", {31'h0, sec}, 32'h0);
      @(posedge clk) want <= 1'h1;
      tick(3);
      chk("up", {8'h0, sel}, {8'h0, pat(1'h1)});
      @(posedge clk) want <= 1'h0;
      tick(3);
      chk("dn", {8'h0, sel}, {8'h0, pat(1'h0)});
   endtask
   task automatic t_err_rst();
      apb(1'h1, cssw_pkg::STAT_OFS, 32'h1);
      chk("ro", {31'h0, e}, 32'h1);
      apb(1'h0, 8'h80, 32'h0);
      chk("unmap", {31'h0, e}, 32'h1);
      @(posedge clk) rr_n <= 1'h0;
      tick(2);
      @(posedge clk) rr_n <= 1'h1;
      tick(2);
      chk("rrp", {8'h0, sel}, {8'h0, 24'hFAC688});
      apb(1'h0, cssw_pkg::CTRL_OFS, 32'h0);
      chk("ctrl", r, 32'h0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      tick(4);
      rstn <= 1'h1;
      tick(3);
      t_reset();
      t_sw();
      t_pin();
      t_err_rst();
      report_and_stop();
   end
   // the whole run takes well under 2000 cycles
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
